// File: core/ulm_defs.svh
`ifndef ULM_DEFS_SVH
`define ULM_DEFS_SVH

`define ULM_OFF_DATA 3'h0
`define ULM_OFF_DIVH 3'h1
`define ULM_OFF_FCTL 3'h2
`define ULM_OFF_LFC 3'h3
`define ULM_OFF_MOC 3'h4
`define ULM_OFF_LST 3'h5
`define ULM_OFF_MSTAT 3'h6
`define ULM_OFF_SCR 3'h7

`define ULM_LFC_STOP 2
`define ULM_LFC_PEN 3
`define ULM_LFC_EVEN 4
`define ULM_LFC_FORCE 5
`define ULM_LFC_BRK 6
`define ULM_LFC_DLAB 7

`define ULM_MOC_DTR 0
`define ULM_MOC_RTS 1
`define ULM_MOC_AUX1 2
`define ULM_MOC_AUX2 3
`define ULM_MOC_LOOP 4
`define ULM_MOC_ANY 5
`define ULM_MOC_IR 6
`define ULM_MOC_PRE 7
`define ULM_MOC_ENH_MASK 8'hE0

`define ULM_FCTL_EN 0
`define ULM_FCTL_RXRST 1
`define ULM_FCTL_TXRST 2
`define ULM_IDENT_NOIRQ 6'h01

`define ULM_RST_LFC 8'h05
`define ULM_RST_MOC 8'h00
`define ULM_RST_SCR 8'hFF
`define ULM_RST_ZERO 8'h00
`define ULM_FULL_MASK 8'hFF

`define ULM_TK_MID 6'h07
`define ULM_TK_LAST 6'h0F
`define ULM_TK_STOP15 6'h17
`define ULM_TK_STOP2 6'h1F
`define ULM_IR_PULSE 6'h03
`define ULM_IR_STRETCH 6'h0F
`define ULM_PRE_LAST 2'h3

`endif

// File: core/ulm_pkg.sv
`include "ulm_defs.svh"
package ulm_pkg;
  typedef logic [7:0] ulm_byte_t;

  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA = 6'b000100,
    RX_PAR = 6'b001000,
    RX_STOP = 6'b010000,
    RX_BRKW = 6'b100000
  } ulm_rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } ulm_tx_state_t;

  function automatic ulm_byte_t ulm_mask(input logic [1:0] wl);
    ulm_mask = `ULM_FULL_MASK >> (2'h3 - wl);
  endfunction : ulm_mask

  // Parity bit to send or expect; forced parity is mark for odd, space for even.
  function automatic logic ulm_parity(input ulm_byte_t d, input logic [1:0] wl,
                                      input logic even, input logic force_bit);
    if (force_bit) begin
      ulm_parity = ~even;
    end else begin
      ulm_parity = (^(d & ulm_mask(wl))) ^ ~even;
    end
  endfunction : ulm_parity
endpackage : ulm_pkg

// File: core/ulm_rx.sv
`timescale 1ns/10ps
`include "ulm_defs.svh"
module ulm_rx (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic rxd,
  input wire logic [1:0] wlen,
  input wire logic par_en,
  input wire logic even,
  input wire logic force_par,
  output logic done,
  output ulm_pkg::ulm_byte_t data,
  output logic par_err,
  output logic frm_err,
  output logic brk
);
  import ulm_pkg::*;

  ulm_rx_state_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  ulm_byte_t shf_q, shf_d;
  logic zero_q, zero_d, pe_q, pe_d, done_d;

  wire bit_last = tick && (cnt_q == `ULM_TK_LAST);
  wire [2:0] last_bit = {1'b1, wlen};
  wire par_exp = ulm_parity(shf_q, wlen, even, force_par);
  wire brk_now = zero_q && !rxd;

  always_comb begin
    st_d = st_q;
    cnt_d = tick ? cnt_q + 6'h01 : cnt_q;
    bit_d = bit_q;
    shf_d = shf_q;
    zero_d = zero_q;
    pe_d = pe_q;
    done_d = 1'b0;
    case (st_q)
      RX_IDLE: begin
        cnt_d = '0;
        if (!rxd) begin
          st_d = RX_START;
        end
      end
      RX_START: begin
        if (tick && cnt_q == `ULM_TK_MID) begin
          cnt_d = '0;
          bit_d = '0;
          shf_d = '0;
          zero_d = 1'b1;
          pe_d = 1'b0;
          st_d = rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (bit_last) begin
          cnt_d = '0;
          shf_d = shf_q | (ulm_byte_t'(rxd) << bit_q);
          zero_d = zero_q & ~rxd;
          bit_d = bit_q + 3'h1;
          if (bit_q == last_bit) begin
            st_d = par_en ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (bit_last) begin
          cnt_d = '0;
          pe_d = (rxd != par_exp);
          zero_d = zero_q & ~rxd;
          st_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (bit_last) begin
          done_d = 1'b1;
          st_d = brk_now ? RX_BRKW : RX_IDLE;
        end
      end
      default: begin
        cnt_d = '0;
        if (rxd) begin
          st_d = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RX_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      shf_q <= '0;
      zero_q <= 1'b0;
      pe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      zero_q <= zero_d;
      pe_q <= pe_d;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
      data <= '0;
      par_err <= 1'b0;
      frm_err <= 1'b0;
      brk <= 1'b0;
    end else begin
      done <= done_d;
      if (done_d) begin
        data <= shf_q;
        par_err <= pe_q;
        frm_err <= !rxd;
        brk <= brk_now;
      end
    end
  end
endmodule : ulm_rx

// File: core/ulm_line_ctrl.sv
// Notes on behaviour
// - Stop length bit: one stop, else 1.5 for 5-bit words, two otherwise.
// - Parity enable adds a parity bit on transmit and checks it on receive.
// - Unforced parity is odd when type bit is 0, even when 1, both ways.
// - Forced parity is mark when type bit is 0, space when 1.
// - Break bit holds the serial output low until software clears it, outside loopback and infrared modes.
// - Divisor access bit maps divisor low, high and fraction over offsets 0, 1 and 2.
// - DTR output is low when its bit is 1 outside loopback, high otherwise.
// - RTS output is low when its bit is 1 outside loopback, high otherwise.
// - Offset 6 shows flow threshold only with enhanced enable and bank bit.
// - Offset 7 shows trigger level only with enhanced enable and bank bit.
// - Auxiliary bits have no pins; in loopback they feed ring and carrier.
// - Loopback routes transmitter and modem outputs back inside; off at reset.
// - Resume-on-any restarts halted transmit; flow characters are not stored.
// - Infrared bit switches coding; writable only enhanced; zero at reset.
// - Prescaler divides baud clock by one or four; writable only enhanced.
// - Data ready shows while any received character is held.
// - Character finishing with full receive store flags overrun and is dropped.
// - Parity error flag belongs to the character at the head.
// - Framing error flag belongs to the head character missing its stop.
// - Break flags a whole low frame; only one break character stored.
// - Holding empty sets on move to shifter, clears on host load.
// - Transmitter idle only when holding path and shifter are both empty.
// - Word length bits select five to eight data bits; six at reset.
// - In loopback clear-to-send follows RTS bit, data-set-ready follows DTR bit.
// - Global error flag stands while any stored byte carries an error.
`timescale 1ns/10ps
`include "ulm_defs.svh"
module ulm_line_ctrl #(
  parameter int RX_DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ulm_pkg::ulm_byte_t reg_wdata,
  output ulm_pkg::ulm_byte_t reg_rdata,
  input wire logic enh_en,
  input wire logic tx_halt,
  input wire logic sw_flow_en,
  input wire ulm_pkg::ulm_byte_t xon_char,
  input wire ulm_pkg::ulm_byte_t xoff_char,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic txd,
  output logic dtr_n,
  output logic rts_n,
  output logic ir_mode
);
  import ulm_pkg::*;

  localparam int AW = $clog2(RX_DEPTH);
  localparam logic [AW:0] CAP_FIFO = (AW + 1)'(RX_DEPTH);
  localparam logic [AW:0] CAP_ONE = (AW + 1)'(1);

  ulm_byte_t lfc_q, moc_q, scr_q, hold_q, tsh_q, tsh_d;
  ulm_byte_t div_lo_q, div_hi_q, div_fr_q, thresh_q, trig_q, rdata_q, rd_val;
  logic fifo_mode_q, oe_q, hold_full_q, halted_q, txd_q, dtr_n_q, rts_n_q, tx_par_q;
  logic tx_load;
  logic [1:0] pre_q;
  logic [15:0] baud_q;
  logic [5:0] txc_q, txc_d, irc_q;
  logic [2:0] txb_q, txb_d;
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, err_q;
  logic [10:0] mem_q [RX_DEPTH];
  ulm_tx_state_t ts_q, ts_d;
  logic rx_done, rx_pe, rx_fe, rx_bi;
  ulm_byte_t rx_data;

  // Register access decode.
  wire dlab = lfc_q[`ULM_LFC_DLAB];
  wire at_data = reg_addr == `ULM_OFF_DATA;
  wire at_fctl = reg_addr == `ULM_OFF_FCTL;
  wire bank_alt = enh_en && moc_q[`ULM_MOC_AUX1];
  wire wr_hold = reg_wr && at_data && !dlab;
  wire wr_div_lo = reg_wr && at_data && dlab;
  wire wr_div_hi = reg_wr && reg_addr == `ULM_OFF_DIVH && dlab;
  wire wr_div_fr = reg_wr && at_fctl && dlab;
  wire wr_fctl = reg_wr && at_fctl && !dlab;
  wire wr_lfc = reg_wr && reg_addr == `ULM_OFF_LFC;
  wire wr_moc = reg_wr && reg_addr == `ULM_OFF_MOC;
  wire wr_thresh = reg_wr && reg_addr == `ULM_OFF_MSTAT && bank_alt;
  wire wr_trig = reg_wr && reg_addr == `ULM_OFF_SCR && bank_alt;
  wire wr_scr = reg_wr && reg_addr == `ULM_OFF_SCR && !bank_alt;
  wire rd_lst = reg_rd && reg_addr == `ULM_OFF_LST;
  wire loop = moc_q[`ULM_MOC_LOOP];

  wire [7:0] moc_wr = (reg_wdata & ~`ULM_MOC_ENH_MASK) |
                      ((enh_en ? reg_wdata : moc_q) & `ULM_MOC_ENH_MASK);

  // Baud tick at sixteen per bit.
  wire [15:0] div_raw = {div_hi_q, div_lo_q};
  wire [15:0] div_last = (div_raw == '0) ? '0 : div_raw - 16'h0001;
  wire pre_tick = !moc_q[`ULM_MOC_PRE] || pre_q == `ULM_PRE_LAST;
  wire tick = pre_tick && baud_q >= div_last;

  // Transmit line and infrared coding.
  wire [1:0] wlen = lfc_q[1:0];
  wire [2:0] last_bit = {1'b1, wlen};
  wire pen = lfc_q[`ULM_LFC_PEN];
  wire [5:0] stop_last = !lfc_q[`ULM_LFC_STOP] ? `ULM_TK_LAST :
                         (wlen == 2'b00) ? `ULM_TK_STOP15 : `ULM_TK_STOP2;
  wire bit_end = txc_q == ((ts_q == TX_STOP) ? stop_last : `ULM_TK_LAST);
  wire tx_bit = (ts_q == TX_START) ? 1'b0 : (ts_q == TX_DATA) ? tsh_q[0] :
                (ts_q == TX_PAR) ? tx_par_q : 1'b1;
  wire tx_line = tx_bit && !lfc_q[`ULM_LFC_BRK];
  wire ir_pulse = !tx_line && txc_q < `ULM_IR_PULSE;
  wire ir_on = moc_q[`ULM_MOC_IR];
  wire ir_dec = !(rxd || irc_q != '0);
  wire rx_in = loop ? tx_line : (ir_on ? ir_dec : rxd);

  // Receive store.
  wire [AW:0] cap = fifo_mode_q ? CAP_FIFO : CAP_ONE;
  wire full = cnt_q >= cap;
  wire has_data = cnt_q != '0;
  wire rx_err = rx_pe || rx_fe || rx_bi;
  wire flow_chr = sw_flow_en && (rx_data == xon_char || rx_data == xoff_char);
  wire push = rx_done && !full && !flow_chr;
  wire pop = reg_rd && at_data && !dlab && has_data;
  wire [10:0] head = mem_q[rp_q];
  wire pop_err = pop && head[10:8] != '0;
  wire rx_flush = wr_fctl && ((reg_wdata[`ULM_FCTL_EN] && reg_wdata[`ULM_FCTL_RXRST]) ||
                              reg_wdata[`ULM_FCTL_EN] != fifo_mode_q);
  wire tx_flush = wr_fctl && reg_wdata[`ULM_FCTL_EN] && reg_wdata[`ULM_FCTL_TXRST];

  wire temt = !hold_full_q && ts_q == TX_IDLE;
  wire [7:0] lst = {err_q != '0, temt, !hold_full_q, head[10:8] & {3{has_data}},
                    oe_q, has_data};
  wire aux_output_one = ~moc_q[`ULM_MOC_AUX1];
  wire aux_output_two = ~moc_q[`ULM_MOC_AUX2];
  wire [3:0] msts = loop ? {~aux_output_two, ~aux_output_one, moc_q[`ULM_MOC_DTR],
                            moc_q[`ULM_MOC_RTS]} : {~cd_n, ~ri_n, ~dsr_n, ~cts_n};

  ulm_rx u_rx (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tick(tick),
    .rxd(rx_in),
    .wlen(wlen),
    .par_en(pen),
    .even(lfc_q[`ULM_LFC_EVEN]),
    .force_par(lfc_q[`ULM_LFC_FORCE]),
    .done(rx_done),
    .data(rx_data),
    .par_err(rx_pe),
    .frm_err(rx_fe),
    .brk(rx_bi)
  );

  // Read data selection.
  always_comb begin
    rd_val = '0;
    if (at_data) begin
      rd_val = dlab ? div_lo_q : head[7:0];
    end else if (reg_addr == `ULM_OFF_DIVH) begin
      rd_val = dlab ? div_hi_q : '0;
    end else if (at_fctl) begin
      rd_val = dlab ? div_fr_q : {fifo_mode_q, fifo_mode_q, `ULM_IDENT_NOIRQ};
    end else if (reg_addr == `ULM_OFF_LFC) begin
      rd_val = lfc_q;
    end else if (reg_addr == `ULM_OFF_MOC) begin
      rd_val = moc_q;
    end else if (reg_addr == `ULM_OFF_LST) begin
      rd_val = lst;
    end else if (reg_addr == `ULM_OFF_MSTAT) begin
      rd_val = bank_alt ? thresh_q : {msts, 4'h0};
    end else begin
      rd_val = bank_alt ? trig_q : scr_q;
    end
  end

  // Transmit sequencer.
  always_comb begin
    ts_d = ts_q;
    txc_d = txc_q;
    txb_d = txb_q;
    tsh_d = tsh_q;
    tx_load = 1'b0;
    case (ts_q)
      TX_IDLE: begin
        if (hold_full_q && !halted_q && tick) begin
          ts_d = TX_START;
          txc_d = '0;
          tsh_d = hold_q & ulm_mask(wlen);
          tx_load = 1'b1;
        end
      end
      TX_START: begin
        if (tick) begin
          txc_d = bit_end ? '0 : txc_q + 6'h01;
          if (bit_end) begin
            ts_d = TX_DATA;
            txb_d = '0;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          txc_d = bit_end ? '0 : txc_q + 6'h01;
          if (bit_end) begin
            tsh_d = tsh_q >> 1;
            txb_d = txb_q + 3'h1;
            if (txb_q == last_bit) begin
              ts_d = pen ? TX_PAR : TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          txc_d = bit_end ? '0 : txc_q + 6'h01;
          if (bit_end) begin
            ts_d = TX_STOP;
          end
        end
      end
      default: begin
        if (tick) begin
          txc_d = bit_end ? '0 : txc_q + 6'h01;
          if (bit_end) begin
            ts_d = TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ts_q <= TX_IDLE;
      txc_q <= '0;
      txb_q <= '0;
      tsh_q <= '0;
      tx_par_q <= 1'b0;
    end else begin
      ts_q <= ts_d;
      txc_q <= txc_d;
      txb_q <= txb_d;
      tsh_q <= tsh_d;
      if (tx_load) begin
        tx_par_q <= ulm_parity(hold_q, wlen, lfc_q[`ULM_LFC_EVEN], lfc_q[`ULM_LFC_FORCE]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lfc_q <= `ULM_RST_LFC;
      moc_q <= `ULM_RST_MOC;
      scr_q <= `ULM_RST_SCR;
      div_lo_q <= `ULM_RST_ZERO;
      div_hi_q <= `ULM_RST_ZERO;
      div_fr_q <= `ULM_RST_ZERO;
      thresh_q <= `ULM_RST_ZERO;
      trig_q <= `ULM_RST_ZERO;
      hold_q <= `ULM_RST_ZERO;
      fifo_mode_q <= 1'b0;
    end else begin
      lfc_q <= wr_lfc ? reg_wdata : lfc_q;
      moc_q <= wr_moc ? moc_wr : moc_q;
      scr_q <= wr_scr ? reg_wdata : scr_q;
      div_lo_q <= wr_div_lo ? reg_wdata : div_lo_q;
      div_hi_q <= wr_div_hi ? reg_wdata : div_hi_q;
      div_fr_q <= wr_div_fr ? reg_wdata : div_fr_q;
      thresh_q <= wr_thresh ? reg_wdata : thresh_q;
      trig_q <= wr_trig ? reg_wdata : trig_q;
      hold_q <= wr_hold ? reg_wdata : hold_q;
      fifo_mode_q <= wr_fctl ? reg_wdata[`ULM_FCTL_EN] : fifo_mode_q;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold_full_q <= 1'b0;
      oe_q <= 1'b0;
      halted_q <= 1'b0;
      pre_q <= '0;
      baud_q <= '0;
      irc_q <= '0;
    end else begin
      hold_full_q <= wr_hold || (hold_full_q && !tx_load && !tx_flush);
      oe_q <= (rx_done && full) || (oe_q && !rd_lst);
      halted_q <= tx_halt || (halted_q && !(rx_done && moc_q[`ULM_MOC_ANY]));
      pre_q <= pre_q + 2'h1;
      baud_q <= tick ? '0 : (pre_tick ? baud_q + 16'h0001 : baud_q);
      irc_q <= rxd ? `ULM_IR_STRETCH : ((tick && irc_q != '0) ? irc_q - 6'h01 : irc_q);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      err_q <= '0;
    end else if (rx_flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      err_q <= '0;
    end else begin
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= pop ? rp_q + 1'b1 : rp_q;
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      err_q <= err_q + (AW + 1)'(push && rx_err) - (AW + 1)'(pop_err);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= {rx_bi, rx_fe, rx_pe, rx_data};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
      txd_q <= 1'b1;
      dtr_n_q <= 1'b1;
      rts_n_q <= 1'b1;
    end else begin
      rdata_q <= reg_rd ? rd_val : rdata_q;
      txd_q <= loop || (ir_on ? ir_pulse : tx_line);
      dtr_n_q <= loop || !moc_q[`ULM_MOC_DTR];
      rts_n_q <= loop || !moc_q[`ULM_MOC_RTS];
    end
  end

  assign reg_rdata = rdata_q;
  assign txd = txd_q;
  assign dtr_n = dtr_n_q;
  assign rts_n = rts_n_q;
  assign ir_mode = moc_q[`ULM_MOC_IR];
endmodule : ulm_line_ctrl

// File: test/ulm_remote_model.sv
`timescale 1ns/10ps
module ulm_remote_model (
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd
);
  int cyc;
  initial begin
    rxd = 1'b1;
    cyc = 0;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rxd <= bits[i];
      repeat (15) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    rxd <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask : send
  // Waits a bounded time for a start bit, then samples n bits at their centres.
  task automatic grab(output logic [11:0] bits, output int t0, input int bt, input int n);
    int k;
    bits = 12'h000;
    t0 = -1;
    k = 0;
    while (txd !== 1'b0 && k < 5000) begin
      @(posedge ref_clk);
      k++;
    end
    if (txd === 1'b0) begin
      t0 = cyc;
      repeat (bt / 2) @(posedge ref_clk);
      for (int i = 0; i < n; i++) begin
        bits[i] = txd;
        if (i < n - 1) repeat (bt) @(posedge ref_clk);
      end
    end
  endtask : grab
endmodule : ulm_remote_model

// File: test/ulm_line_ctrl_props.sv
`timescale 1ns/10ps
`include "ulm_defs.svh"
module ulm_line_ctrl_props #(
  parameter int RX_DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ulm_pkg::ulm_byte_t reg_wdata,
  input wire ulm_pkg::ulm_byte_t reg_rdata,
  input wire logic enh_en,
  input wire logic txd,
  input wire logic dtr_n,
  input wire logic rts_n,
  input wire logic ir_mode
);
  import ulm_pkg::*;
  ulm_byte_t moc_q;
  ulm_byte_t lfc_q;
  wire moc_wr = reg_wr && reg_addr == `ULM_OFF_MOC;
  wire lfc_wr = reg_wr && reg_addr == `ULM_OFF_LFC;
  // Mirrors the control registers; upper modem bits only change when enhanced.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      moc_q <= `ULM_RST_MOC;
      lfc_q <= `ULM_RST_LFC;
    end else begin
      if (moc_wr) moc_q <= enh_en ? reg_wdata : {moc_q[7:5], reg_wdata[4:0]};
      if (lfc_wr) lfc_q <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_moc_settled;
    $stable(moc_q) [*3];
  endsequence
  sequence s_brk_held;
    (lfc_q[6] && !moc_q[4]) [*3];
  endsequence
  sequence s_lst_rd;
    reg_rd && reg_addr == `ULM_OFF_LST;
  endsequence
  dtr_level_a: assert property (s_moc_settled |-> dtr_n == (~moc_q[0] | moc_q[4]))
    else $error("dtr output level wrong");
  rts_level_a: assert property (s_moc_settled |-> rts_n == (~moc_q[1] | moc_q[4]))
    else $error("rts output level wrong");
  ir_bit_a: assert property (s_moc_settled |-> ir_mode == moc_q[6])
    else $error("infrared mode wrong");
  brk_hold_a: assert property (s_brk_held |-> !txd)
    else $error("break not held low");
  loop_txd_a: assert property (moc_q[4] [*3] |-> txd)
    else $error("serial output not idle in loopback");
  reset_outs_a: assert property ($rose(nrst) |-> txd && dtr_n && rts_n && !ir_mode)
    else $error("outputs wrong after reset");
  idle_empty_a: assert property (s_lst_rd |=> !reg_rdata[6] || reg_rdata[5])
    else $error("idle without empty holding");
  head_flags_a: assert property (s_lst_rd |=> reg_rdata[0] || reg_rdata[4:2] == 3'h0)
    else $error("error flags without data");
  err_sum_a: assert property (s_lst_rd |=> reg_rdata[4:2] == 3'h0 || reg_rdata[7])
    else $error("global error flag missing");
endmodule : ulm_line_ctrl_props
bind ulm_line_ctrl ulm_line_ctrl_props #(.RX_DEPTH(RX_DEPTH)) i_props (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .enh_en(enh_en), .txd(txd),
  .dtr_n(dtr_n), .rts_n(rts_n), .ir_mode(ir_mode)
);

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
  import ulm_pkg::*;
  logic ref_clk, nrst, reg_wr, reg_rd, enh_en, rxd, cts_n, dsr_n, ri_n, cd_n;
  logic txd, dtr_n, rts_n, ir_mode;
  logic [2:0] reg_addr;
  ulm_byte_t reg_wdata, reg_rdata;
  int fails, check_count;
  // Format, modem control and data for each transmit case.
  logic [23:0] tx_tab [8] = '{24'h0300A5, 24'h0B00A5, 24'h1B00A5, 24'h2B003C,
                              24'h3B003C, 24'h040015, 24'h05002A, 24'h068055};
  // Line frame, bit count, expected status and data for each receive case.
  logic [31:0] rx_tab [4] = '{32'h54AB61A5, 32'h74ABE5A5, 32'h14ABE9A5, 32'h000CF900};
  ulm_line_ctrl #(.RX_DEPTH(64)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .enh_en(enh_en), .tx_halt(1'b0), .sw_flow_en(1'b0), .xon_char(8'h11), .xoff_char(8'h13),
    .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .cd_n(cd_n), .txd(txd),
    .dtr_n(dtr_n), .rts_n(rts_n), .ir_mode(ir_mode));
  ulm_remote_model i_far (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  task automatic end_sim();
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    check_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("[FAIL] %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wr(input logic [2:0] a, input ulm_byte_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [2:0] a, input ulm_byte_t e, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({4'h0, reg_rdata}, {4'h0, e}, what);
  endtask : rdc
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    ulm_byte_t lf, d, dm;
    int w, pe, bt, st, t0, t1;
    logic [11:0] e, e2, g1, g2;
    {fails, check_count} = '0;
    {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, enh_en} = '0;
    {cts_n, dsr_n, ri_n, cd_n} = 4'b0101;
    repeat (10) @(posedge ref_clk);
    chk({txd, dtr_n, rts_n, ir_mode}, 12'hE, "reset pins");
    nrst <= 1'b1;
    rdc(3'h3, 8'h05, "format reset");
    rdc(3'h4, 8'h00, "modem reset");
    rdc(3'h5, 8'h60, "status reset");
    rdc(3'h6, 8'h50, "modem status");
    rdc(3'h7, 8'hFF, "scratch reset");
    wr(3'h4, 8'hE3);
    rdc(3'h4, 8'h03, "enhanced bits refused");
    chk({dtr_n, rts_n, ir_mode}, 12'h0, "modem outputs low");
    wr(3'h4, 8'h1F);
    rdc(3'h6, 8'hF0, "loop modem status");
    chk({txd, dtr_n, rts_n}, 12'h7, "loop outputs");
    wr(3'h4, 8'h17);
    rdc(3'h6, 8'h70, "loop aux bits");
    @(posedge ref_clk);
    enh_en <= 1'b1;
    wr(3'h4, 8'hC4);
    #1;
    chk(ir_mode, 12'h1, "infrared on");
    wr(3'h7, 8'h5A);
    wr(3'h6, 8'h33);
    rdc(3'h7, 8'h5A, "trigger bank");
    rdc(3'h6, 8'h33, "threshold bank");
    wr(3'h4, 8'h00);
    rdc(3'h7, 8'hFF, "scratch kept");
    rdc(3'h6, 8'h50, "status bank");
    wr(3'h3, 8'h83);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rdc(3'h0, 8'h01, "divisor low");
    wr(3'h3, 8'h03);
    rdc(3'h1, 8'h00, "divisor hidden");
    for (int i = 0; i < 8; i++) begin
      lf = tx_tab[i][23:16];
      d = tx_tab[i][7:0];
      wr(3'h4, tx_tab[i][15:8]);
      wr(3'h3, lf);
      w = 5 + lf[1:0];
      pe = lf[3];
      bt = tx_tab[i][15] ? 64 : 16;
      st = !lf[2] ? 16 : (w == 5 ? 24 : 32);
      dm = d & (8'hFF >> (8 - w));
      e = 12'h000;
      for (int k = 0; k < w; k++) e[1 + k] = d[k];
      if (pe == 1) e[1 + w] = lf[5] ? ~lf[4] : (^dm) ^ ~lf[4];
      e[1 + w + pe] = 1'b1;
      e2 = 12'h000;
      for (int k = 0; k < w; k++) e2[1 + k] = ~d[k];
      if (pe == 1) e2[1 + w] = lf[5] ? ~lf[4] : (^(~d & (8'hFF >> (8 - w)))) ^ ~lf[4];
      e2[1 + w + pe] = 1'b1;
      fork
        begin
          i_far.grab(g1, t0, bt, 2 + w + pe);
          i_far.grab(g2, t1, bt, 2 + w + pe);
        end
        begin
          wr(3'h0, d);
          repeat (6) @(posedge ref_clk);
          wr(3'h0, ~d);
          rdc(3'h5, 8'h00, "transmit busy");
        end
      join
      chk(g1, e, "frame bits");
      chk(g2, e2, "second frame bits");
      chk_rng(t1 - t0, bt * (1 + w + pe) + st * bt / 16,
              bt * (1 + w + pe) + st * bt / 16 + bt / 16 + 2, "gap");
      repeat (2 * bt) @(posedge ref_clk);
      rdc(3'h5, 8'h60, "transmit idle");
    end
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h43);
    repeat (50) @(posedge ref_clk);
    chk(txd, 12'h0, "break low");
    wr(3'h3, 8'h1B);
    repeat (3) @(posedge ref_clk);
    chk(txd, 12'h1, "break released");
    for (int i = 0; i < 4; i++) begin
      i_far.send(rx_tab[i][31:20], rx_tab[i][19:16]);
      rdc(3'h5, rx_tab[i][15:8], "receive status");
      rdc(3'h0, rx_tab[i][7:0], "receive data");
      rdc(3'h5, 8'h60, "receive drained");
    end
    i_far.send(12'h54A, 11);
    i_far.send(12'h4B4, 11);
    rdc(3'h5, 8'h63, "overrun");
    rdc(3'h0, 8'hA5, "first kept");
    rdc(3'h5, 8'h60, "overrun cleared");
    end_sim();
  end
endmodule : tb
